// file: legacy_compat_gate.sv
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module legacy_compat_gate
  import compat_gate_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic legacy_compat_fuse,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cpu_req,
  input wire logic cpu_io_instr,
  input wire logic [15:0] cpu_addr,
  output compat_gate_pkg::dec_t cpu_dec,
  output compat_gate_pkg::feat_t feat,
  input wire logic [4:0] rst_cause,
  output logic [2:0] wdt_prescale,
  output logic wdt_enable,
  output logic [7:0] osc_cal,
  output logic [7:0] eint_sense,
  output logic [3:0] baud_hi,
  input wire logic [2:0] xmem_strobe,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pa_pullup,
  input wire logic [7:0] pc_in,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe,
  input wire logic [7:0] pf_in,
  output logic [7:0] pf_out,
  output logic [7:0] pf_oe,
  input wire logic [4:0] pg_in,
  output logic [4:0] pg_out,
  output logic [4:0] pg_oe
);
  import compat_gate_pkg::*;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic compat;
    logic [7:0] pa_out;
    logic [7:0] pa_dir;
    logic [7:0] pc_out;
    logic [7:0] pc_dir;
    logic [7:0] pf_out;
    logic [7:0] pf_dir;
    logic [4:0] pg_out;
    logic [4:0] pg_dir;
    logic [7:0] osc_cal;
    logic [4:0] rst_stat;
    logic [2:0] wdt_pre;
    logic wdt_en;
    logic [2:0] wdt_win;
    logic [7:0] eint_cfg;
    logic [3:0] baud_hi;
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] pin;
    logic [7:0] rdata;
    dec_t dec;
    feat_t feat;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic wr;
  logic [15:0] da;
  logic [4:0] rst_mask;

  assign wr = reg_wr;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    rst_mask = st_ff.compat ? RST_COMPAT_MASK : RST_FULL_MASK;
    da = cpu_addr;

    // pin synchroniser: change taken once stages two and three agree
    nxt_st.s1 = {pg_in, pf_in, pc_in, pa_in};
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < PIN_W; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.pin[i] = st_ff.s3[i];
      end
    end

    // short io instructions reach only the 64 legacy locations
    if (cpu_io_instr) begin
      da = IO_BASE + {10'h000, cpu_addr[5:0]};
    end
    nxt_st.dec = '0;
    nxt_st.dec.valid = cpu_req;
    nxt_st.dec.addr = da;
    if (cpu_req) begin
      if (da <= GPR_TOP) begin
        nxt_st.dec.sel_gpr = 1'b1;
      end else if (da <= IO_TOP) begin
        nxt_st.dec.sel_io = 1'b1;
      end else if (da <= EXT_TOP && !st_ff.compat) begin
        nxt_st.dec.sel_ext_io = 1'b1;
      end else if (st_ff.compat && da >= RAM_BASE_COMPAT &&
                   da <= RAM_TOP_COMPAT) begin
        nxt_st.dec.sel_ram = 1'b1;
      end else if (!st_ff.compat && da >= RAM_BASE_NORM &&
                   da <= RAM_TOP_NORM) begin
        nxt_st.dec.sel_ram = 1'b1;
      end else begin
        nxt_st.dec.sel_xmem = 1'b1;
      end
    end

    // watchdog change window
    if (st_ff.wdt_win != 3'h0) begin
      nxt_st.wdt_win = st_ff.wdt_win - 3'h1;
    end

    // reset causes: set wins over a software clear in the same cycle
    if (wr && hit(reg_addr, OFF_RST_STAT)) begin
      nxt_st.rst_stat = st_ff.rst_stat & reg_wdata[4:0];
    end
    nxt_st.rst_stat = (nxt_st.rst_stat | rst_cause) & rst_mask;

    // register writes
    if (wr) begin
      if (hit(reg_addr, OFF_PA_OUT)) begin
        nxt_st.pa_out = reg_wdata;
      end else if (hit(reg_addr, OFF_PA_DIR)) begin
        nxt_st.pa_dir = reg_wdata;
      end else if (hit(reg_addr, OFF_PC_OUT)) begin
        nxt_st.pc_out = reg_wdata;
      end else if (hit(reg_addr, OFF_PC_DIR)) begin
        nxt_st.pc_dir = reg_wdata;
      end else if (hit(reg_addr, OFF_PF_OUT)) begin
        nxt_st.pf_out = reg_wdata;
      end else if (hit(reg_addr, OFF_PF_DIR)) begin
        nxt_st.pf_dir = reg_wdata;
      end else if (hit(reg_addr, OFF_PG_OUT)) begin
        nxt_st.pg_out = reg_wdata[4:0];
      end else if (hit(reg_addr, OFF_PG_DIR)) begin
        nxt_st.pg_dir = reg_wdata[4:0];
      end else if (hit(reg_addr, OFF_OSC_CAL)) begin
        if (!st_ff.compat) begin
          nxt_st.osc_cal = reg_wdata;
        end
      end else if (hit(reg_addr, OFF_WDT_CTL)) begin
        if (st_ff.compat || st_ff.wdt_win != 3'h0) begin
          nxt_st.wdt_pre = reg_wdata[WDT_PRE_MSB:0];
          nxt_st.wdt_en = reg_wdata[WDT_EN_BIT];
          nxt_st.wdt_win = 3'h0;
        end else if (reg_wdata[WDT_CE_BIT] && reg_wdata[WDT_EN_BIT]) begin
          nxt_st.wdt_win = WDT_WIN_CYC;
        end else if (reg_wdata[WDT_EN_BIT]) begin
          nxt_st.wdt_en = 1'b1;
        end
      end else if (hit(reg_addr, OFF_EINT_CFG)) begin
        nxt_st.eint_cfg = reg_wdata;
      end else if (hit(reg_addr, OFF_BAUD_HI)) begin
        nxt_st.baud_hi = reg_wdata[3:0];
      end
    end

    // register reads: data stand only in the cycle after the strobe
    nxt_st.rdata = 8'h00;
    if (reg_rd) begin
      if (hit(reg_addr, OFF_PA_OUT)) begin
        nxt_st.rdata = st_ff.pa_out;
      end else if (hit(reg_addr, OFF_PA_DIR)) begin
        nxt_st.rdata = st_ff.pa_dir;
      end else if (hit(reg_addr, OFF_PA_PIN)) begin
        nxt_st.rdata = st_ff.pin[PA_LSB +: 8];
      end else if (hit(reg_addr, OFF_PC_OUT)) begin
        nxt_st.rdata = st_ff.pc_out;
      end else if (hit(reg_addr, OFF_PC_DIR)) begin
        nxt_st.rdata = st_ff.compat ? 8'hff : st_ff.pc_dir;
      end else if (hit(reg_addr, OFF_PC_PIN)) begin
        nxt_st.rdata = st_ff.compat ? 8'h00 : st_ff.pin[PC_LSB +: 8];
      end else if (hit(reg_addr, OFF_PF_OUT)) begin
        nxt_st.rdata = st_ff.pf_out;
      end else if (hit(reg_addr, OFF_PF_DIR)) begin
        nxt_st.rdata = st_ff.compat ? 8'h00 : st_ff.pf_dir;
      end else if (hit(reg_addr, OFF_PF_PIN)) begin
        nxt_st.rdata = st_ff.pin[PF_LSB +: 8];
      end else if (hit(reg_addr, OFF_PG_OUT)) begin
        nxt_st.rdata = {3'h0, st_ff.pg_out};
      end else if (hit(reg_addr, OFF_PG_DIR)) begin
        nxt_st.rdata = {3'h0, st_ff.pg_dir};
      end else if (hit(reg_addr, OFF_PG_PIN)) begin
        nxt_st.rdata = st_ff.compat ? 8'h00 : {3'h0, st_ff.pin[PG_LSB +: 5]};
      end else if (hit(reg_addr, OFF_OSC_CAL)) begin
        nxt_st.rdata = st_ff.osc_cal;
      end else if (hit(reg_addr, OFF_RST_STAT)) begin
        nxt_st.rdata = {3'h0, st_ff.rst_stat};
      end else if (hit(reg_addr, OFF_WDT_CTL)) begin
        nxt_st.rdata = {4'h0, st_ff.wdt_en, st_ff.wdt_pre};
      end else if (hit(reg_addr, OFF_EINT_CFG)) begin
        nxt_st.rdata = st_ff.eint_cfg;
      end else if (hit(reg_addr, OFF_BAUD_HI)) begin
        nxt_st.rdata = {4'h0, st_ff.baud_hi};
      end else if (hit(reg_addr, OFF_MODE_STAT)) begin
        nxt_st.rdata = {7'h00, st_ff.compat};
      end
    end

    // feature gating follows the latched mode
    nxt_st.feat.usart1_en = !nxt_st.compat;
    nxt_st.feat.usart_sync_en = !nxt_st.compat;
    nxt_st.feat.timer3_en = !nxt_st.compat;
    nxt_st.feat.ocr_c_en = !nxt_st.compat;
    nxt_st.feat.twi_en = !nxt_st.compat;
    nxt_st.feat.boot_en = !nxt_st.compat;
    nxt_st.feat.xmem_release_en = !nxt_st.compat;
    nxt_st.feat.xmem_sector_ws_en = !nxt_st.compat;
    nxt_st.feat.rx_fifo_en = !nxt_st.compat;
    nxt_st.feat.ext_vec_en = !nxt_st.compat;

    if (srst) begin
      nxt_st = '0;
      nxt_st.osc_cal = OSC_CAL_RST;
      nxt_st.compat = legacy_compat_fuse;
      nxt_st.feat = {$bits(feat_t){!legacy_compat_fuse}};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign reg_rdata = st_ff.rdata;
  assign cpu_dec = st_ff.dec;
  assign feat = st_ff.feat;
  assign wdt_prescale = st_ff.wdt_pre;
  assign wdt_enable = st_ff.wdt_en;
  assign osc_cal = st_ff.osc_cal;
  assign eint_sense = st_ff.compat ? 8'h00 : st_ff.eint_cfg;
  assign baud_hi = st_ff.compat ? 4'h0 : st_ff.baud_hi;

  // reset gates the enables directly, so no clock edge is needed
  assign pa_out = st_ff.pa_out;
  assign pa_oe = srst ? 8'h00 : st_ff.pa_dir;
  assign pa_pullup = st_ff.pa_out & ~pa_oe;

  assign pc_out = st_ff.pc_out;
  always_comb begin
    if (legacy_compat_fuse && srst) begin
      pc_oe = 8'hff;
    end else if (srst) begin
      pc_oe = 8'h00;
    end else if (st_ff.compat) begin
      pc_oe = 8'hff;
    end else begin
      pc_oe = st_ff.pc_dir;
    end
  end

  assign pf_out = st_ff.pf_out;
  assign pf_oe = (srst || st_ff.compat) ? 8'h00 : st_ff.pf_dir;

  always_comb begin
    if (legacy_compat_fuse && srst) begin
      pg_out = {2'h0, PG_STROBE_RST};
      pg_oe = {2'h0, PG_STROBE_OE};
    end else if (srst) begin
      pg_out = st_ff.pg_out;
      pg_oe = 5'h00;
    end else if (st_ff.compat) begin
      pg_out = {2'h0, xmem_strobe};
      pg_oe = {2'h0, PG_STROBE_OE};
    end else begin
      pg_out = st_ff.pg_out;
      pg_oe = st_ff.pg_dir;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence osc_wr_compat_s;
    wr && hit(reg_addr, OFF_OSC_CAL) && st_ff.compat && clk_en;
  endsequence

  sequence wdt_wr_compat_s;
    wr && hit(reg_addr, OFF_WDT_CTL) && st_ff.compat && clk_en;
  endsequence

  sequence io_req_s;
    cpu_req && cpu_io_instr && clk_en;
  endsequence

  compat_static_a: assert property (
    !$past(srst) |-> st_ff.compat == $past(st_ff.compat))
    else $error("compat select changed while running");

  io_short_a: assert property (
    io_req_s |=> cpu_dec.sel_io && !cpu_dec.sel_ext_io)
    else $error("short io access left the legacy io space");

  ext_io_off_a: assert property (
    st_ff.compat |-> !cpu_dec.sel_ext_io)
    else $error("extended io decoded in compat mode");

  osc_lock_a: assert property (
    osc_wr_compat_s |=> $stable(osc_cal))
    else $error("calibration changed in compat mode");

  wdt_direct_a: assert property (
    wdt_wr_compat_s |=> wdt_prescale == $past(reg_wdata[WDT_PRE_MSB:0]))
    else $error("watchdog change refused in compat mode");

  rst_flags_a: assert property (
    st_ff.compat |-> st_ff.rst_stat[4:2] == 3'h0)
    else $error("extra reset flag in compat mode");

  eint_level_a: assert property (
    st_ff.compat |-> eint_sense == 8'h00)
    else $error("edge sense offered in compat mode");

  twi_gate_a: assert property (
    feat.twi_en != st_ff.compat && feat.timer3_en != st_ff.compat)
    else $error("feature gating does not follow mode");

  pa_hiz_a: assert property (disable iff (1'b0)
    srst |-> pa_oe == 8'h00)
    else $error("first port driven during reset");

  pg_strobe_a: assert property (disable iff (1'b0)
    srst && legacy_compat_fuse |-> pg_out[2:0] == PG_STROBE_RST
      && pg_oe[2:0] == PG_STROBE_OE)
    else $error("strobe pins wrong during reset");

  pc_drive_a: assert property (disable iff (1'b0)
    srst && legacy_compat_fuse |-> pc_oe == 8'hff)
    else $error("third port released during reset");

endmodule : legacy_compat_gate

`default_nettype wire

// file: compat_gate_pkg.sv
package compat_gate_pkg;

  // --------------------------------------------------------------------------
  // register map (byte offsets on the register port)
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFF_PA_OUT = 8'h00;
  localparam logic [7:0] OFF_PA_DIR = 8'h01;
  localparam logic [7:0] OFF_PA_PIN = 8'h02;
  localparam logic [7:0] OFF_PC_OUT = 8'h03;
  localparam logic [7:0] OFF_PC_DIR = 8'h04;
  localparam logic [7:0] OFF_PC_PIN = 8'h05;
  localparam logic [7:0] OFF_PF_OUT = 8'h06;
  localparam logic [7:0] OFF_PF_DIR = 8'h07;
  localparam logic [7:0] OFF_PF_PIN = 8'h08;
  localparam logic [7:0] OFF_PG_OUT = 8'h09;
  localparam logic [7:0] OFF_PG_DIR = 8'h0a;
  localparam logic [7:0] OFF_PG_PIN = 8'h0b;
  localparam logic [7:0] OFF_OSC_CAL = 8'h0c;
  localparam logic [7:0] OFF_RST_STAT = 8'h0d;
  localparam logic [7:0] OFF_WDT_CTL = 8'h0e;
  localparam logic [7:0] OFF_EINT_CFG = 8'h0f;
  localparam logic [7:0] OFF_BAUD_HI = 8'h10;
  localparam logic [7:0] OFF_MODE_STAT = 8'h11;

  // --------------------------------------------------------------------------
  // field layouts and reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] OSC_CAL_RST = 8'h80;
  localparam logic [4:0] RST_COMPAT_MASK = 5'h03;
  localparam logic [4:0] RST_FULL_MASK = 5'h1f;
  localparam int WDT_PRE_MSB = 2;
  localparam int WDT_EN_BIT = 3;
  localparam int WDT_CE_BIT = 4;
  localparam logic [2:0] WDT_WIN_CYC = 3'h4;
  localparam logic [2:0] PG_STROBE_RST = 3'h3;
  localparam logic [2:0] PG_STROBE_OE = 3'h7;
  localparam int PA_LSB = 0;
  localparam int PC_LSB = 8;
  localparam int PF_LSB = 16;
  localparam int PG_LSB = 24;
  localparam int PIN_W = 29;

  // --------------------------------------------------------------------------
  // data-space map
  // --------------------------------------------------------------------------
  localparam logic [15:0] GPR_TOP = 16'h001f;
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] IO_TOP = 16'h005f;
  localparam logic [15:0] EXT_TOP = 16'h00ff;
  localparam logic [15:0] RAM_BASE_NORM = 16'h0100;
  localparam logic [15:0] RAM_TOP_NORM = 16'h10ff;
  localparam logic [15:0] RAM_BASE_COMPAT = 16'h0060;
  localparam logic [15:0] RAM_TOP_COMPAT = 16'h0fff;

  typedef struct packed {
    logic valid;
    logic sel_gpr;
    logic sel_io;
    logic sel_ext_io;
    logic sel_ram;
    logic sel_xmem;
    logic [15:0] addr;
  } dec_t;

  typedef struct packed {
    logic usart1_en;
    logic usart_sync_en;
    logic timer3_en;
    logic ocr_c_en;
    logic twi_en;
    logic boot_en;
    logic xmem_release_en;
    logic xmem_sector_ws_en;
    logic rx_fifo_en;
    logic ext_vec_en;
  } feat_t;

endpackage : compat_gate_pkg

// file: cpu_path_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// data-access side of the core, plus the memory strobes
// ----------------------------------------------------------------------------
module cpu_path_model (
  input wire logic core_clk,
  input wire logic acc_go,
  input wire logic acc_io,
  input wire logic [15:0] acc_addr,
  input wire logic [2:0] strobe_pat,
  output logic cpu_req,
  output logic cpu_io_instr,
  output logic [15:0] cpu_addr,
  output logic [2:0] xmem_strobe
);
  logic [15:0] last_addr_ff = 16'h0000;

  always_comb begin
    cpu_req = acc_go;
    cpu_io_instr = acc_go & acc_io;
    if (!acc_go) begin
      // idle bus: never leave the old address standing
      cpu_addr = ~last_addr_ff;
    end else if (acc_io) begin
      cpu_addr = {10'h000, acc_addr[5:0]};
    end else begin
      cpu_addr = acc_addr;
    end
    xmem_strobe = strobe_pat;
  end

  always_ff @(posedge core_clk) begin
    if (acc_go) begin
      last_addr_ff <= cpu_addr;
    end
  end
endmodule : cpu_path_model

`default_nettype wire

// file: legacy_compat_gate_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module legacy_compat_gate_tb_top;
  import compat_gate_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic fuse = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic go = 1'b0;
  logic io = 1'b0;
  logic [15:0] a = 16'h0000;
  logic [2:0] pat = 3'h0;
  logic [4:0] rst_cause = 5'h00;
  logic [7:0] pa_in = 8'h5a;
  logic [7:0] pc_in = 8'h96;
  logic [7:0] pf_in = 8'hc3;
  logic [4:0] pg_in = 5'h15;
  logic [7:0] reg_rdata;
  logic cpu_req;
  logic cpu_io_instr;
  logic [15:0] cpu_addr;
  logic [2:0] xmem_strobe;
  dec_t cpu_dec;
  feat_t feat;
  logic [2:0] wdt_prescale;
  logic wdt_enable;
  logic [7:0] osc_cal, eint_sense, pa_out, pa_oe, pa_pullup;
  logic [3:0] baud_hi;
  logic [7:0] pc_out, pc_oe, pf_out, pf_oe;
  logic [4:0] pg_out, pg_oe;
  int fail_count = 0;
  int comparisons = 0;

  always #10 core_clk = ~core_clk;

  legacy_compat_gate i_dut (
    .core_clk, .srst, .clk_en(1'b1), .legacy_compat_fuse(fuse),
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cpu_req, .cpu_io_instr, .cpu_addr, .cpu_dec, .feat, .rst_cause,
    .wdt_prescale, .wdt_enable, .osc_cal, .eint_sense, .baud_hi,
    .xmem_strobe, .pa_in, .pa_out, .pa_oe, .pa_pullup,
    .pc_in, .pc_out, .pc_oe, .pf_in, .pf_out, .pf_oe,
    .pg_in, .pg_out, .pg_oe
  );

  cpu_path_model i_cpu (
    .core_clk, .acc_go(go), .acc_io(io), .acc_addr(a),
    .strobe_pat(pat), .cpu_req, .cpu_io_instr, .cpu_addr, .xmem_strobe
  );

  // --------------------------------------------------------------------------
  // shared bus cycles and compare
  // --------------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic dec(input logic i, input logic [15:0] ad,
                     input logic [4:0] s, input logic [15:0] ex);
    @(posedge core_clk);
    go <= 1'b1;
    io <= i;
    a <= ad;
    @(posedge core_clk);
    go <= 1'b0;
    #1;
    chk(16'({cpu_dec.valid, cpu_dec.sel_gpr, cpu_dec.sel_io,
             cpu_dec.sel_ext_io, cpu_dec.sel_ram, cpu_dec.sel_xmem}),
        16'({1'b1, s}));
    chk(cpu_dec.addr, ex);
  endtask : dec

  // --------------------------------------------------------------------------
  // scenarios, each run in both modes
  // --------------------------------------------------------------------------
  task automatic do_reset(input logic c);
    @(posedge core_clk);
    srst <= 1'b1;
    fuse <= c;
    #1;
    chk(16'(pa_oe), 16'h0000);
    chk(16'(pc_oe), c ? 16'h00ff : 16'h0000);
    chk(16'(pg_oe), c ? 16'h0007 : 16'h0000);
    chk(16'(pg_out[2:0]), c ? 16'h0003 : 16'h0000);
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
  endtask : do_reset

  task automatic t_feat(input logic c);
    chk(16'(feat[9:5]), c ? 16'h0000 : 16'h001f);
    chk(16'(feat[4:0]), c ? 16'h0000 : 16'h001f);
  endtask : t_feat

  task automatic t_decode(input logic c);
    dec(1'b0, 16'h001f, 5'h10, 16'h001f);
    dec(1'b0, 16'h0020, 5'h08, 16'h0020);
    dec(1'b1, 16'h003f, 5'h08, 16'h005f);
    dec(1'b0, 16'h0060, c ? 5'h02 : 5'h04, 16'h0060);
    dec(1'b0, 16'h00ff, c ? 5'h02 : 5'h04, 16'h00ff);
    dec(1'b0, 16'h0100, 5'h02, 16'h0100);
    dec(1'b0, 16'h1000, c ? 5'h01 : 5'h02, 16'h1000);
    dec(1'b0, 16'h1100, 5'h01, 16'h1100);
  endtask : t_decode

  task automatic t_regs(input logic c);
    logic [7:0] d;
    wr(OFF_OSC_CAL, 8'h3c);
    chk(16'(osc_cal), c ? 16'h0080 : 16'h003c);
    wr(OFF_EINT_CFG, 8'haa);
    chk(16'(eint_sense), c ? 16'h0000 : 16'h00aa);
    wr(OFF_BAUD_HI, 8'h0f);
    chk(16'(baud_hi), c ? 16'h0000 : 16'h000f);
    wr(OFF_WDT_CTL, 8'h0d);
    chk(16'({wdt_enable, wdt_prescale}), c ? 16'h000d : 16'h0008);
    wr(OFF_WDT_CTL, 8'h18);
    wr(OFF_WDT_CTL, 8'h0a);
    chk(16'({wdt_enable, wdt_prescale}), 16'h000a);
    @(posedge core_clk);
    rst_cause <= 5'h1f;
    @(posedge core_clk);
    rst_cause <= 5'h00;
    rd(OFF_RST_STAT, d);
    chk(16'(d), c ? 16'h0003 : 16'h001f);
    wr(OFF_RST_STAT, 8'h00);
    rd(OFF_RST_STAT, d);
    chk(16'(d), 16'h0000);
    rd(8'h40, d);
    chk(16'(d), 16'h0000);
    @(posedge core_clk);
    fuse <= ~c;
    rd(OFF_MODE_STAT, d);
    chk(16'(d[0]), 16'(c));
  endtask : t_regs

  task automatic t_ports(input logic c);
    logic [7:0] d;
    wr(OFF_PA_DIR, 8'h0f);
    wr(OFF_PA_OUT, 8'hff);
    chk(16'({pa_oe, pa_out}), 16'h0fff);
    chk(16'(pa_pullup), 16'h00f0);
    rd(OFF_PA_PIN, d);
    chk(16'(d), 16'h005a);
    wr(OFF_PC_DIR, 8'h00);
    wr(OFF_PF_DIR, 8'hff);
    chk(16'(pc_oe), c ? 16'h00ff : 16'h0000);
    chk(16'(pf_oe), c ? 16'h0000 : 16'h00ff);
    wr(OFF_PC_OUT, 8'h3c);
    wr(OFF_PF_OUT, 8'h5a);
    chk(16'({pc_out, pf_out}), 16'h3c5a);
    rd(OFF_PC_PIN, d);
    chk(16'(d), c ? 16'h0000 : 16'h0096);
    rd(OFF_PF_PIN, d);
    chk(16'(d), 16'h00c3);
    rd(OFF_PG_PIN, d);
    chk(16'(d), c ? 16'h0000 : 16'h0015);
    wr(OFF_PG_OUT, 8'h12);
    @(posedge core_clk);
    pat <= 3'h5;
    @(posedge core_clk);
    #1;
    chk(16'(pg_out[2:0]), c ? 16'h0005 : 16'h0002);
    chk(16'(pg_oe), c ? 16'h0007 : 16'h0000);
  endtask : t_ports

  task automatic conclude();
    $display("Mismatches %0d, comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (2000) @(posedge core_clk);
    fail_count++;
    conclude();
  end

  initial begin
    do_reset(1'b0);
    t_feat(1'b0);
    t_decode(1'b0);
    t_regs(1'b0);
    t_ports(1'b0);
    // port a still has outputs enabled here: reset must float them
    do_reset(1'b1);
    t_feat(1'b1);
    t_decode(1'b1);
    t_regs(1'b1);
    t_ports(1'b1);
    conclude();
  end
endmodule : legacy_compat_gate_tb_top

`default_nettype wire
